// ---- dcpi_device.sv ----
// device end: serial port, transfer strobe, profile pins, sync clock
`timescale 1ns/100ps
`default_nettype none
// Operation
// - reset pin restores all register defaults
// - strobe rise copies buffer to active registers
// - strobe synchronous to sync clock, fixed latency
// - host holds strobe two sync periods
// - sync clock is quarter system clock
// - sync clock can be switched off
// - strobe and profile pins change only after sync rise
// - profile config field is bits 14:12
// - profile pins modulate, sweep or ramp
// - serial port ignored unless select low
// - write on sclk rise, read on fall
// - line zero serial only, line one ramp
// - oscillator select enables crystal stage
// - master drives sync out, slave aligns
// - update reaches output after 29 clocks, 34 in modulation modes
// - profile change reaches output after 34
module dcpi_device #(
  parameter int LAT_TONE = dcpi_pkg::LAT_UPDATE,
  parameter int LAT_MOD  = dcpi_pkg::LAT_PROFILE
) (
  input  wire logic                         i_clk,
  input  wire logic                         i_rst_b,
  dcpi_if.device                            pins,
  output logic [dcpi_pkg::DATA_W-1:0]       o_ftw,
  output logic [dcpi_pkg::POW_W-1:0]        o_pow,
  output logic [dcpi_pkg::AMP_W-1:0]        o_amp,
  output logic                              o_sweep_run,
  output logic                              o_ramp_en,
  output logic                              o_ramp_up,
  output logic                              o_xtal_osc_en
);
  localparam int NS = 12;
  localparam int DW = dcpi_pkg::DATA_W;

  // ==========================================================================
  // pin synchronisers
  logic [NS-1:0] meta;
  logic [NS-1:0] syn;
  logic [NS-1:0] raw;
  assign raw = {pins.profile_pins, pins.sync_in, pins.clk_mode_sel, pins.master_reset,
                pins.io_update, pins.sdio[1], pins.sdio[0], pins.sclk, pins.cs_b};

  // every pin is asynchronous to i_clk, so two stages before use
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta <= '0;
      syn  <= '0;
    end else begin
      meta <= raw;
      syn  <= meta;
    end
  end

  logic       cs_b_s, sclk_s, sdi_s, sdio1_s, upd_s, mrst_s, clk_sel_s, sync_in_s;
  logic [3:0] prof_s;
  assign {prof_s, sync_in_s, clk_sel_s, mrst_s, upd_s, sdio1_s, sdi_s, sclk_s, cs_b_s} = syn;

  // ==========================================================================
  // edge history
  logic sclk_prev, sync_in_prev;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_prev    <= 1'b0;
      sync_in_prev <= 1'b0;
    end else begin
      sclk_prev    <= sclk_s;
      sync_in_prev <= sync_in_s;
    end
  end
  logic sclk_rise, sclk_fall;
  assign sclk_rise = sclk_s & ~sclk_prev;
  assign sclk_fall = ~sclk_s & sclk_prev;

  // ==========================================================================
  // serial port and buffer registers
  logic [dcpi_pkg::CNT_W-1:0]   bit_cnt, next_bit_cnt;
  logic [dcpi_pkg::INSTR_W-1:0] instr, next_instr;
  logic [DW-1:0]                data, next_data;
  logic [DW-1:0]                rd_shift, next_rd_shift;
  logic                         sdo, next_sdo, sdo_oe, next_sdo_oe;
  logic [DW-1:0]                shadow [dcpi_pkg::NUM_REGS];
  logic [DW-1:0]                next_shadow [dcpi_pkg::NUM_REGS];
  logic [DW-1:0]                active [dcpi_pkg::NUM_REGS];
  logic [DW-1:0]                next_active [dcpi_pkg::NUM_REGS];
  logic [dcpi_pkg::ADDR_W-1:0]  addr;
  logic                         addr_ok;
  logic [DW-1:0]                rd_word;
  logic [DW-1:0]                fr1;

  assign addr    = instr[dcpi_pkg::ADDR_W-1:0];
  assign addr_ok = (32'(addr) < dcpi_pkg::NUM_REGS);
  assign rd_word = addr_ok ? shadow[addr] : dcpi_pkg::WORD_RESET;
  assign fr1     = active[dcpi_pkg::ADDR_FR1];

  // bits shift in on sclk rise and out on sclk fall
  always_comb begin
    next_bit_cnt  = bit_cnt;
    next_instr    = instr;
    next_data     = data;
    next_rd_shift = rd_shift;
    next_sdo      = sdo;
    next_sdo_oe   = sdo_oe;
    next_shadow   = shadow;
    if (mrst_s) begin
      for (int i = 0; i < dcpi_pkg::NUM_REGS; i++) begin
        next_shadow[i] = (i == 0) ? dcpi_pkg::FR1_RESET : dcpi_pkg::WORD_RESET;
      end
      next_bit_cnt = '0;
      next_sdo_oe  = 1'b0;
      next_sdo     = 1'b0;
    end else if (cs_b_s) begin
      next_bit_cnt = '0;
      next_sdo_oe  = 1'b0;
    end else begin
      if (sclk_rise) begin
        if (32'(bit_cnt) < dcpi_pkg::INSTR_W) begin
          next_instr = {instr[dcpi_pkg::INSTR_W-2:0], sdi_s};
        end else if (!instr[dcpi_pkg::READ_BIT] && 32'(bit_cnt) < dcpi_pkg::FRAME_W) begin
          next_data = {data[DW-2:0], sdi_s};
          if (32'(bit_cnt) == dcpi_pkg::FRAME_W - 1 && addr_ok) begin
            next_shadow[addr] = next_data;
          end
        end
        if (32'(bit_cnt) < dcpi_pkg::FRAME_W) begin
          next_bit_cnt = bit_cnt + 6'h01;
        end
      end
      // read data leaves on line zero only; lines 1..3 never drive
      if (sclk_fall && instr[dcpi_pkg::READ_BIT] && 32'(bit_cnt) >= dcpi_pkg::INSTR_W
          && 32'(bit_cnt) < dcpi_pkg::FRAME_W) begin
        if (32'(bit_cnt) == dcpi_pkg::INSTR_W) begin
          next_sdo      = rd_word[DW-1];
          next_rd_shift = {rd_word[DW-2:0], 1'b0};
        end else begin
          next_sdo      = rd_shift[DW-1];
          next_rd_shift = {rd_shift[DW-2:0], 1'b0};
        end
        next_sdo_oe = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bit_cnt  <= '0;
      instr    <= '0;
      data     <= '0;
      rd_shift <= '0;
      sdo      <= 1'b0;
      sdo_oe   <= 1'b0;
      for (int i = 0; i < dcpi_pkg::NUM_REGS; i++) begin
        shadow[i] <= (i == 0) ? dcpi_pkg::FR1_RESET : dcpi_pkg::WORD_RESET;
      end
    end else begin
      bit_cnt  <= next_bit_cnt;
      instr    <= next_instr;
      data     <= next_data;
      rd_shift <= next_rd_shift;
      sdo      <= next_sdo;
      sdo_oe   <= next_sdo_oe;
      shadow   <= next_shadow;
    end
  end

  // ==========================================================================
  // sync clock divider and multi-device alignment
  logic [1:0] phase, next_phase;
  logic       sync_clk, next_sync_clk, sync_out, next_sync_out, sync_edge;

  always_comb begin
    next_phase = phase + 2'h1;
    if (!fr1[dcpi_pkg::MASTER_BIT] && sync_in_s && !sync_in_prev) begin
      next_phase = dcpi_pkg::ALIGN_PH;
    end
    if (mrst_s) begin
      next_phase = '0;
    end
    // starts and stops only on whole periods, so switching it on or off never shows a runt pulse
    next_sync_clk = next_phase[1] & (sync_clk | ~(phase[1] | fr1[dcpi_pkg::SYNC_OFF_BIT]));
    next_sync_out = next_phase[1] & fr1[dcpi_pkg::MASTER_BIT];
  end
  // sampling shares the edge on which the sync clock pin rises
  assign sync_edge = (next_phase == dcpi_pkg::SYNC_RISE_PH) && (phase != dcpi_pkg::SYNC_RISE_PH);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      phase    <= '0;
      sync_clk <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      phase    <= next_phase;
      sync_clk <= next_sync_clk;
      sync_out <= next_sync_out;
    end
  end
  assign pins.sync_clk  = sync_clk;
  assign pins.sync_out  = sync_out;
  assign pins.sdio_d_o  = {3'h0, sdo};
  assign pins.sdio_d_oe = {3'h0, sdo_oe};

  // ==========================================================================
  // transfer strobe and profile sampling
  logic       upd_prev, next_upd_prev;
  logic [3:0] prof, next_prof;

  // a late strobe simply waits for the next sync edge: one period of slip
  always_comb begin
    next_upd_prev = upd_prev;
    next_prof     = prof;
    next_active   = active;
    if (mrst_s) begin
      next_upd_prev = 1'b0;
      next_prof     = '0;
      for (int i = 0; i < dcpi_pkg::NUM_REGS; i++) begin
        next_active[i] = (i == 0) ? dcpi_pkg::FR1_RESET : dcpi_pkg::WORD_RESET;
      end
    end else if (sync_edge) begin
      next_upd_prev = upd_s;
      next_prof     = prof_s;
      if (upd_s && !upd_prev) begin
        next_active = shadow;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      upd_prev <= 1'b0;
      prof     <= '0;
      for (int i = 0; i < dcpi_pkg::NUM_REGS; i++) begin
        active[i] <= (i == 0) ? dcpi_pkg::FR1_RESET : dcpi_pkg::WORD_RESET;
      end
    end else begin
      upd_prev <= next_upd_prev;
      prof     <= next_prof;
      active   <= next_active;
    end
  end

  // ==========================================================================
  // profile word selection and latency line
  logic [dcpi_pkg::PPC_W-1:0]  profile_pin_config;
  logic [dcpi_pkg::WORD_W-1:0] cur_word;
  logic [DW-1:0]               sel_ftw;
  logic [dcpi_pkg::POW_W-1:0]  sel_pow;
  logic [dcpi_pkg::AMP_W-1:0]  sel_amp;
  logic                        mod_mode;
  assign profile_pin_config = fr1[dcpi_pkg::PPC_LSB +: dcpi_pkg::PPC_W];

  always_comb begin
    sel_ftw  = active[dcpi_pkg::ADDR_FTW];
    sel_pow  = active[dcpi_pkg::ADDR_POW][dcpi_pkg::POW_W-1:0];
    sel_amp  = active[dcpi_pkg::ADDR_AMP][dcpi_pkg::AMP_W-1:0];
    mod_mode = 1'b1;
    case (profile_pin_config)
      dcpi_pkg::PPC_FREQ: begin
        if (prof[0]) sel_ftw = active[dcpi_pkg::ADDR_ALT];
      end
      dcpi_pkg::PPC_PHASE: begin
        if (prof[0]) sel_pow = active[dcpi_pkg::ADDR_ALT][dcpi_pkg::POW_W-1:0];
      end
      dcpi_pkg::PPC_AMPL: begin
        if (prof[0]) sel_amp = active[dcpi_pkg::ADDR_ALT][dcpi_pkg::AMP_W-1:0];
      end
      default: mod_mode = 1'b0;
    endcase
    cur_word = {sel_amp, sel_pow, sel_ftw};
  end

  // a full line rather than a counter, so closely spaced changes all survive
  logic [dcpi_pkg::WORD_W-1:0] dly [LAT_MOD];
  logic [dcpi_pkg::WORD_W-1:0] next_dly [LAT_MOD];
  logic [dcpi_pkg::WORD_W-1:0] tap;
  always_comb begin
    next_dly[0] = cur_word;
    for (int i = 1; i < LAT_MOD; i++) begin
      next_dly[i] = dly[i-1];
    end
    tap = mod_mode ? dly[LAT_MOD-2] : dly[LAT_TONE-2];
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < LAT_MOD; i++) begin
        dly[i] <= '0;
      end
    end else begin
      dly <= next_dly;
    end
  end

  // ==========================================================================
  // registered outputs
  logic next_sweep, next_ramp_en, next_ramp_up;
  always_comb begin
    next_sweep   = (profile_pin_config == dcpi_pkg::PPC_SWEEP) & prof[0];
    next_ramp_en = (profile_pin_config == dcpi_pkg::PPC_RAMP) | fr1[dcpi_pkg::RAMP_PIN_BIT];
    next_ramp_up = (profile_pin_config == dcpi_pkg::PPC_RAMP) ? prof[0] : sdio1_s;
    if (!next_ramp_en) next_ramp_up = 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {o_amp, o_pow, o_ftw} <= '0;
      o_sweep_run           <= 1'b0;
      o_ramp_en             <= 1'b0;
      o_ramp_up             <= 1'b0;
      o_xtal_osc_en         <= 1'b0;
    end else begin
      {o_amp, o_pow, o_ftw} <= tap;
      o_sweep_run           <= next_sweep;
      o_ramp_en             <= next_ramp_en;
      o_ramp_up             <= next_ramp_up;
      o_xtal_osc_en         <= clk_sel_s;
    end
  end
endmodule
`default_nettype wire

// ---- dcpi_host.sv ----
// host end: drives the serial port, strobe, profile and control pins
`timescale 1ns/100ps
`default_nettype none
module dcpi_host #(
  parameter int HALF  = dcpi_pkg::SCLK_HALF,
  parameter int RHOLD = dcpi_pkg::RESET_HOLD
) (
  input  wire logic                          i_clk,
  input  wire logic                          i_rst_b,
  dcpi_if.host                               pins,
  input  wire logic                          i_xfer_valid,
  input  wire logic                          i_xfer_read,
  input  wire logic [dcpi_pkg::ADDR_W-1:0]   i_xfer_addr,
  input  wire logic [dcpi_pkg::DATA_W-1:0]   i_xfer_data,
  output logic                               o_xfer_ready,
  output logic                               o_rd_valid,
  output logic [dcpi_pkg::DATA_W-1:0]        o_rd_data,
  input  wire logic                          i_update_req,
  input  wire logic [3:0]                    i_profile,
  input  wire logic                          i_xtal_sel,
  input  wire logic                          i_reset_req
);
  localparam int FW = dcpi_pkg::FRAME_W;

  // ==========================================================================
  // synchronisers for the pins the device drives
  logic [1:0] meta, syn;
  logic       sync_prev;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta      <= '0;
      syn       <= '0;
      sync_prev <= 1'b0;
    end else begin
      meta      <= {pins.sync_clk, pins.sdio[0]};
      syn       <= meta;
      sync_prev <= syn[1];
    end
  end
  logic sync_rise;
  assign sync_rise = syn[1] & ~sync_prev;

  // ==========================================================================
  // serial engine: sclk made here by dividing i_clk
  dcpi_pkg::dcpi_host_st_t st, next_st;
  logic [7:0]                 div, next_div;
  logic [dcpi_pkg::CNT_W-1:0] bits, next_bits;
  logic [FW-1:0]              tx, next_tx;
  logic [dcpi_pkg::DATA_W-1:0] rx, next_rx;
  logic rd, next_rd, cs_b, next_cs_b, sclk, next_sclk, sdo, next_sdo, oe, next_oe;
  logic next_rd_valid;

  always_comb begin
    next_st = st; next_div = div; next_bits = bits; next_tx = tx; next_rx = rx;
    next_rd = rd; next_cs_b = cs_b; next_sclk = sclk; next_sdo = sdo; next_oe = oe;
    next_rd_valid = 1'b0;
    case (st)
      dcpi_pkg::DCPI_H_IDLE: begin
        // cs_b stays high long enough for the device to let go of line zero
        if (32'(div) < HALF) next_div = div + 8'h01;
        if (i_xfer_valid && 32'(div) >= HALF) begin
          next_tx   = {i_xfer_read, 4'h0, i_xfer_addr, i_xfer_data} << 1;
          next_sdo  = i_xfer_read;
          next_oe   = 1'b1;
          next_rd   = i_xfer_read;
          next_cs_b = 1'b0;
          next_div  = '0;
          next_bits = '0;
          next_st   = dcpi_pkg::DCPI_H_SHIFT;
        end
      end
      dcpi_pkg::DCPI_H_SHIFT: begin
        next_div = div + 8'h01;
        if (32'(div) == HALF - 1) begin
          next_div  = '0;
          next_sclk = ~sclk;
          if (!sclk) begin
            next_bits = bits + 6'h01;
            if (rd && 32'(bits) >= dcpi_pkg::INSTR_W) begin
              next_rx = {rx[dcpi_pkg::DATA_W-2:0], syn[0]};
            end
          end else if (32'(bits) == FW) begin
            next_cs_b     = 1'b1;
            next_oe       = 1'b0;
            next_rd_valid = rd;
            next_st       = dcpi_pkg::DCPI_H_IDLE;
          end else begin
            // line released before the device launches read bits
            next_sdo = tx[FW-1];
            next_tx  = tx << 1;
            next_oe  = ~(rd && 32'(bits) >= dcpi_pkg::INSTR_W);
          end
        end
      end
      default: next_st = dcpi_pkg::DCPI_H_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= dcpi_pkg::DCPI_H_IDLE; div <= '0; bits <= '0; tx <= '0; rx <= '0;
      rd <= 1'b0; cs_b <= 1'b1; sclk <= 1'b0; sdo <= 1'b0; oe <= 1'b0;
      o_rd_valid <= 1'b0; o_rd_data <= '0; o_xfer_ready <= 1'b0;
    end else begin
      st <= next_st; div <= next_div; bits <= next_bits; tx <= next_tx; rx <= next_rx;
      rd <= next_rd; cs_b <= next_cs_b; sclk <= next_sclk; sdo <= next_sdo; oe <= next_oe;
      o_rd_valid   <= next_rd_valid;
      o_rd_data    <= next_rd_valid ? next_rx : o_rd_data;
      o_xfer_ready <= (next_st == dcpi_pkg::DCPI_H_IDLE) && !i_xfer_valid
                      && 32'(next_div) >= HALF;
    end
  end

  // ==========================================================================
  // strobe, profile, reset and oscillator select pins
  logic       pend, next_pend, upd, next_upd;
  logic [1:0] hold, next_hold;
  logic [3:0] prof, next_prof;
  logic [7:0] rcnt, next_rcnt;
  always_comb begin
    next_pend = pend | i_update_req;
    next_upd  = upd;
    next_hold = hold;
    next_prof = prof;
    next_rcnt = (rcnt != 8'h00) ? rcnt - 8'h01 : 8'h00;
    if (i_reset_req) next_rcnt = 8'(RHOLD);
    if (sync_rise) begin
      next_prof = i_profile;
      if (upd) begin
        next_hold = hold + 2'h1;
        if (32'(hold) + 1 >= dcpi_pkg::UPD_HOLD) next_upd = 1'b0;
      end else if (pend) begin
        next_upd  = 1'b1;
        next_pend = i_update_req;
        next_hold = '0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend <= 1'b0; upd <= 1'b0; hold <= '0; prof <= '0; rcnt <= '0;
      pins.clk_mode_sel <= 1'b0;
    end else begin
      pend <= next_pend; upd <= next_upd; hold <= next_hold; prof <= next_prof;
      rcnt <= next_rcnt;
      pins.clk_mode_sel <= i_xtal_sel;
    end
  end

  assign pins.cs_b         = cs_b;
  assign pins.sclk         = sclk;
  assign pins.sdio_h_o     = {3'h0, sdo};
  assign pins.sdio_h_oe    = {3'h0, oe};
  assign pins.io_update    = upd;
  assign pins.profile_pins = prof;
  assign pins.master_reset = (rcnt != 8'h00);
endmodule
`default_nettype wire

// ---- dcpi_if.sv ----
// pin bundle joining the synthesizer and its host controller
`timescale 1ns/100ps
`default_nettype none
interface dcpi_if;
  logic       cs_b;
  logic       sclk;
  logic       io_update;
  logic       master_reset;
  logic       clk_mode_sel;
  logic [3:0] profile_pins;
  logic [3:0] sdio_h_o;
  logic [3:0] sdio_h_oe;
  logic [3:0] sdio_d_o;
  logic [3:0] sdio_d_oe;
  logic [3:0] sdio;
  logic       sync_clk;
  logic       sync_out;
  logic       sync_in;

  // data lines resolve with a pull-up when nobody drives
  assign sdio = (sdio_h_oe & sdio_h_o) | (sdio_d_oe & sdio_d_o) | ~(sdio_h_oe | sdio_d_oe);

  modport device (
    input  cs_b, sclk, io_update, master_reset, clk_mode_sel, profile_pins, sdio, sync_in,
    output sdio_d_o, sdio_d_oe, sync_clk, sync_out
  );
  modport host (
    input  sdio, sync_clk,
    output cs_b, sclk, io_update, master_reset, clk_mode_sel, profile_pins, sdio_h_o,
           sdio_h_oe
  );
endinterface
`default_nettype wire

// ---- dcpi_pkg.sv ----
// constants and types shared by both ends of the synthesizer control pins
package dcpi_pkg;
  // ==========================================================================
  // serial frame layout
  localparam int INSTR_W  = 8;
  localparam int DATA_W   = 32;
  localparam int FRAME_W  = INSTR_W + DATA_W;
  localparam int READ_BIT = 7;
  localparam int ADDR_W   = 3;
  localparam int NUM_REGS = 5;
  localparam int CNT_W    = 6;
  // ==========================================================================
  // register indices
  localparam logic [ADDR_W-1:0] ADDR_FR1 = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_FTW = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_POW = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_AMP = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_ALT = 3'h4;
  // ==========================================================================
  // function_reg_one fields and reset values
  localparam int PPC_LSB      = 12;
  localparam int PPC_W        = 3;
  localparam int SYNC_OFF_BIT = 8;
  localparam int MASTER_BIT   = 7;
  localparam int RAMP_PIN_BIT = 6;
  localparam logic [DATA_W-1:0] FR1_RESET  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;
  // profile_pin_config codes
  localparam logic [PPC_W-1:0] PPC_NONE  = 3'h0;
  localparam logic [PPC_W-1:0] PPC_FREQ  = 3'h1;
  localparam logic [PPC_W-1:0] PPC_PHASE = 3'h2;
  localparam logic [PPC_W-1:0] PPC_AMPL  = 3'h3;
  localparam logic [PPC_W-1:0] PPC_SWEEP = 3'h4;
  localparam logic [PPC_W-1:0] PPC_RAMP  = 3'h5;
  // ==========================================================================
  // channel word widths and timing
  localparam int POW_W       = 14;
  localparam int AMP_W       = 10;
  localparam int WORD_W      = DATA_W + POW_W + AMP_W;
  localparam int LAT_UPDATE  = 29;
  localparam int LAT_PROFILE = 34;
  localparam logic [1:0] SYNC_RISE_PH = 2'h2;
  localparam logic [1:0] ALIGN_PH     = 2'h0;
  localparam int SCLK_HALF    = 8;
  localparam int RESET_HOLD   = 4;
  localparam int UPD_HOLD     = 2;
  typedef enum logic {DCPI_H_IDLE, DCPI_H_SHIFT} dcpi_host_st_t;
endpackage

// ---- dcpi_properties.sv ----
// assertions on the pins between host and synthesizer
`timescale 1ns/100ps
`default_nettype none
module dcpi_properties (
  input wire logic       i_clk,
  input wire logic       i_rst_b,
  input wire logic       cs_b,
  input wire logic       sclk,
  input wire logic       io_update,
  input wire logic       master_reset,
  input wire logic       sync_clk,
  input wire logic [3:0] sdio_h_oe,
  input wire logic [3:0] sdio_d_oe
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  // ====================
  // age since the reset pin; the sync phase may jump before it saturates
  logic [3:0] mr_age;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) mr_age <= 4'hF;
    else if (master_reset) mr_age <= 4'h0;
    else if (mr_age != 4'hF) mr_age <= mr_age + 4'h1;
  end
  // ====================
  // pin relations
  property p_sync_low; $rose(sync_clk) |-> !$past(sync_clk, 2); endproperty
  property p_sync_high; $rose(sync_clk) && mr_age == 4'hF |=> sync_clk ##1 !sync_clk; endproperty
  property p_dev_oe; $rose(sdio_d_oe[0]) |-> !cs_b && !sdio_h_oe[0]; endproperty
  property p_no_fight; !(sdio_h_oe[0] && sdio_d_oe[0]); endproperty
  property p_sclk_idle; cs_b |-> !sclk; endproperty
  property p_upd_width; $rose(io_update) |=> io_update[*3]; endproperty
  property p_rst_width; $rose(master_reset) |-> master_reset[*4] ##1 !master_reset; endproperty
  property p_lines; sdio_d_oe[3:1] == 3'h0 && sdio_h_oe[3:1] == 3'h0; endproperty
  a_sync_low: assert property (p_sync_low) else $error("sync low short");
  a_sync_high: assert property (p_sync_high) else $error("sync high wrong");
  a_dev_oe: assert property (p_dev_oe) else $error("device drives unselected");
  a_no_fight: assert property (p_no_fight) else $error("data line fight");
  a_sclk_idle: assert property (p_sclk_idle) else $error("sclk not idle");
  a_upd_width: assert property (p_upd_width) else $error("strobe too short");
  a_rst_width: assert property (p_rst_width) else $error("reset pin width");
  a_lines: assert property (p_lines) else $error("upper lines driven");
  c_upd: cover property ($rose(io_update));
  c_read: cover property ($rose(sdio_d_oe[0]));
  c_rst: cover property ($rose(master_reset));
endmodule
`default_nettype wire

// ---- dds_control_pin_interface_bench.sv ----
// self-checking bench joining host and synthesizer ends
`timescale 1ns/100ps
`default_nettype none
module dds_control_pin_interface_bench;
  localparam logic [31:0] F = 32'h1234_5678;
  localparam logic [31:0] A = 32'h0BAD_F00D;
  logic        i_clk = 1'b0, i_rst_b = 1'b0, valid = 1'b0, rd = 1'b0;
  logic        upd = 1'b0, xtal = 1'b0, rreq = 1'b0, rdy, sweep, ramp_en, xosc, ramp_up, rdv;
  logic [2:0]  addr = 3'h0;
  logic [3:0]  prof = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, ftw;
  logic [13:0] pow;
  logic [9:0]  amp;
  logic [55:0] cur;
  logic [55:0] rows [3] = '{56'hFFFF_FFFF_FFFF_FF, 56'h0000_0001_0004_01,
                            56'hA5A5_5A5A_AAA5_55};
  int          errors = 0, check_count = 0, n, s, so_rise = 0, sc_chg = 0, rd_cnt = 0;
  dcpi_if bus ();
  dcpi_device u_dcpi_device (.i_clk(i_clk), .i_rst_b(i_rst_b), .pins(bus), .o_ftw(ftw),
    .o_pow(pow), .o_amp(amp), .o_sweep_run(sweep), .o_ramp_en(ramp_en), .o_ramp_up(ramp_up),
    .o_xtal_osc_en(xosc));
  dcpi_host u_dcpi_host (.i_clk(i_clk), .i_rst_b(i_rst_b), .pins(bus), .i_xfer_valid(valid),
    .i_xfer_read(rd), .i_xfer_addr(addr), .i_xfer_data(wdata), .o_xfer_ready(rdy),
    .o_rd_valid(rdv), .o_rd_data(rdata), .i_update_req(upd), .i_profile(prof),
    .i_xtal_sel(xtal), .i_reset_req(rreq));
  dcpi_properties u_dcpi_properties (.i_clk(i_clk), .i_rst_b(i_rst_b), .cs_b(bus.cs_b),
    .sclk(bus.sclk), .io_update(bus.io_update), .master_reset(bus.master_reset),
    .sync_clk(bus.sync_clk), .sdio_h_oe(bus.sdio_h_oe), .sdio_d_oe(bus.sdio_d_oe));
  // ====================
  // clock, edge counters on the sync pins, and a counter of read-valid cycles
  always #25 i_clk = ~i_clk;
  always @(posedge bus.sync_out) so_rise++;
  always @(bus.sync_clk) sc_chg++;
  always @(posedge i_clk) if (rdv === 1'b1) rd_cnt++;
  initial bus.sync_in = 1'b0;
  // ====================
  // helpers
  task automatic cyc(input int k);
    repeat (k) @(negedge i_clk);
  endtask
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one whole frame; ready is awaited before and after, so frames never overlap
  task automatic xfer(input logic r, input logic [2:0] a, input logic [31:0] d);
    for (n = 0; n < 2000 && rdy !== 1'b1; n++) cyc(1);
    {rd, addr, wdata, valid} = {r, a, d, 1'b1};
    cyc(1);
    valid = 1'b0;
    for (n = 0; n < 2000 && rdy !== 1'b1; n++) cyc(1);
  endtask
  // strobe, then old words must stand until the latency has run out
  task automatic update(input logic [55:0] w, input int lat = dcpi_pkg::LAT_UPDATE);
    upd = 1'b1;
    cyc(1);
    upd = 1'b0;
    for (n = 0; n < 50 && bus.io_update !== 1'b1; n++) cyc(1);
    // the strobe is taken on the sync edge five cycles after the pin rises
    cyc(lat + 4);
    chk("early", {ftw, pow, amp}, cur);
    cyc(1);
    chk("words", {ftw, pow, amp}, w);
    cur = w;
  endtask
  task automatic finish_test;
    if (errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog well beyond some twenty-four frames
  initial begin
    repeat (80000) @(posedge i_clk);
    errors++;
    finish_test();
  end
  // ====================
  // main sequence
  initial begin
    cyc(5);
    i_rst_b = 1'b1;
    cur = '0;
    cyc(2);
    foreach (rows[i]) begin
      xfer(0, dcpi_pkg::ADDR_FTW, rows[i][55:24]);
      xfer(0, dcpi_pkg::ADDR_POW, {18'h0, rows[i][23:10]});
      xfer(0, dcpi_pkg::ADDR_AMP, {22'h0, rows[i][9:0]});
      chk("held", {ftw, pow, amp}, cur);
      update(rows[i]);
      xfer(1, dcpi_pkg::ADDR_FTW, 32'h0);
      chk("read", rdata, rows[i][55:24]);
    end
    rreq = 1'b1;
    cyc(1);
    rreq = 1'b0;
    cyc(60);
    chk("rst_out", {ftw, pow, amp}, 64'h0);
    xfer(1, dcpi_pkg::ADDR_FTW, 32'h0);
    chk("rst_reg", rdata, dcpi_pkg::WORD_RESET);
    cur = '0;
    xtal = 1'b1;
    cyc(8);
    chk("xosc", xosc, 1'b1);
    // every profile code with pin zero high
    xfer(0, dcpi_pkg::ADDR_FTW, F);
    xfer(0, dcpi_pkg::ADDR_ALT, A);
    prof = 4'h1;
    update({F, 24'h0});
    for (logic [3:0] c = 4'h0; c < 4'h6; c++) begin
      xfer(0, dcpi_pkg::ADDR_FR1, {17'h0, c[2:0], 12'h0});
      update({(c == 1) ? A : F, (c == 2) ? A[13:0] : 14'h0, (c == 3) ? A[9:0] : 10'h0},
             (c >= 4'h1 && c <= 4'h3) ? dcpi_pkg::LAT_PROFILE : dcpi_pkg::LAT_UPDATE);
      chk("sweep", sweep, c == 4);
      chk("ramp_up", ramp_up, c == 5);
      chk("ramp", ramp_en, c == 5);
    end
    xfer(0, dcpi_pkg::ADDR_FR1, {17'h0, dcpi_pkg::PPC_FREQ, 12'h0});
    update({A, 24'h0}, dcpi_pkg::LAT_PROFILE);
    prof = 4'h0;
    for (n = 0; n < 20 && bus.profile_pins[0] !== 1'b0; n++) cyc(1);
    cyc(dcpi_pkg::LAT_PROFILE + 4);
    chk("prof_early", ftw, A);
    cyc(1);
    chk("prof", ftw, F);
    cur = {F, 24'h0};
    // slave: a sync_in rise just after a sync rise restarts the phase a cycle late
    for (n = 0; n < 8 && bus.sync_clk !== 1'b0; n++) cyc(1);
    for (n = 0; n < 8 && bus.sync_clk !== 1'b1; n++) cyc(1);
    bus.sync_in = 1'b1;
    cyc(4);
    chk("slave_hold", bus.sync_clk, 1'b0);
    cyc(1);
    chk("slave_rise", bus.sync_clk, 1'b1);
    xfer(0, dcpi_pkg::ADDR_FR1,
         (32'h1 << dcpi_pkg::MASTER_BIT) | (32'h1 << dcpi_pkg::RAMP_PIN_BIT));
    update(cur);
    chk("ramp_line", ramp_en, 1'b1);
    chk("ramp_up_line", ramp_up, 1'b1);
    {s, n} = {so_rise, sc_chg};
    cyc(16);
    chk("sync_out", so_rise - s, 4);
    chk("sync_rate", sc_chg - n, 8);
    xfer(0, dcpi_pkg::ADDR_FR1, 32'h1 << dcpi_pkg::SYNC_OFF_BIT);
    update(cur);
    s = sc_chg;
    cyc(16);
    chk("sync_off", sc_chg - s, 0);
    chk("rd_valid", rd_cnt, 4);
    finish_test();
  end
endmodule
`default_nettype wire
